// ===== hw/mfi_decode.sv
`timescale 1ns/1ps
module mfi_decode import mfi_pkg::*; #(
  parameter int NUM_TERM = 6
) (
  input wire logic [NUM_TERM-1:0] level_in,
  input wire logic [NUM_TERM*CODE_W-1:0] code_in,
  mfi_fn_if.src fn_if
);

  logic [NUM_TERM-1:0][FN_COUNT-1:0] act_t;
  logic [NUM_TERM-1:0][FN_COUNT-1:0] cfg_t;

  if (NUM_TERM < 1 || NUM_TERM > 16) begin : g_bad
    $error("mfi_decode: NUM_TERM out of range");
  end

  // ---
  // per terminal decode
  // ---
  for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
    mfi_code_type code;
    logic asserted;
    logic [FN_COUNT-1:0] onehot;
    assign code = code_in[t*CODE_W +: CODE_W];
    assign asserted = mfi_is_nc(code) ? ~level_in[t] // see [RULE_24]
                                      : level_in[t];
    assign onehot = (code < FN_COUNT) ? (FN_COUNT'(1) << code) : '0;
    assign cfg_t[t] = onehot;
    assign act_t[t] = asserted ? onehot : '0;
  end

  always_comb begin
    fn_if.act = '0;
    fn_if.cfg = '0;
    for (int i = 0; i < NUM_TERM; i++) begin
      fn_if.act = fn_if.act | act_t[i];
      fn_if.cfg = fn_if.cfg | cfg_t[i];
    end
  end

endmodule : mfi_decode

// ===== hw/mfi_fn_if.sv
`timescale 1ns/1ps
interface mfi_fn_if;
  import mfi_pkg::*;
  logic [FN_COUNT-1:0] act;
  logic [FN_COUNT-1:0] cfg;
  modport src (output act, output cfg);
  modport dst (input act, input cfg);
endinterface : mfi_fn_if

// ===== hw/mfi_pkg.sv
package mfi_pkg;

  // ---
  // function codes
  // ---
  localparam int CODE_W = 6;
  localparam int FN_COUNT = 37;
  typedef logic [CODE_W-1:0] mfi_code_type;

  localparam mfi_code_type FN_RESET_NO = 6'h05;
  localparam mfi_code_type FN_RAMP_SEL1 = 6'h07;
  localparam mfi_code_type FN_RAMP_SEL2 = 6'h08;
  localparam mfi_code_type FN_BLOCK_NO = 6'h09;
  localparam mfi_code_type FN_BLOCK_NC = 6'h0a;
  localparam mfi_code_type FN_FREQ_UP = 6'h0b;
  localparam mfi_code_type FN_FREQ_DOWN = 6'h0c;
  localparam mfi_code_type FN_CNT_CLEAR = 6'h0d;
  localparam mfi_code_type FN_SEQ_RUN = 6'h0e;
  localparam mfi_code_type FN_SEQ_PAUSE = 6'h0f;
  localparam mfi_code_type FN_AUX_MOTOR1 = 6'h10;
  localparam mfi_code_type FN_ESTOP_NO = 6'h13;
  localparam mfi_code_type FN_ESTOP_NC = 6'h14;
  localparam mfi_code_type FN_SEL_CURRENT = 6'h15;
  localparam mfi_code_type FN_SEL_AUX = 6'h16;
  localparam mfi_code_type FN_CMD_TERMINAL = 6'h17;
  localparam mfi_code_type FN_LINEAR_RAMP = 6'h18;
  localparam mfi_code_type FN_FSTOP_NC = 6'h19;
  localparam mfi_code_type FN_FSTOP_NO = 6'h1a;
  localparam mfi_code_type FN_PARAM_LOCK = 6'h1b;
  localparam mfi_code_type FN_PID_OFF = 6'h1c;
  localparam mfi_code_type FN_JOG_REVERSE = 6'h1d;
  localparam mfi_code_type FN_RESET_NC = 6'h1e;
  localparam mfi_code_type FN_SECOND_FREQ = 6'h1f;
  localparam mfi_code_type FN_SECOND_CMD = 6'h20;
  localparam mfi_code_type FN_SEQ_SHOT = 6'h21;
  localparam mfi_code_type FN_SHUTOFF_NO = 6'h23;
  localparam mfi_code_type FN_SHUTOFF_NC = 6'h24;
  localparam int AUX_MOTORS = 3;

  // ---
  // analog frequency sources
  // ---
  typedef enum logic [1:0] {
    SRC_VOLTAGE = 2'h0,
    SRC_CURRENT = 2'h1,
    SRC_AUXILIARY = 2'h2
  } mfi_asrc_type;

  // ---
  // timing and widths
  // ---
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int STEP_REPEAT_MS = 10;
  localparam int STEP_REPEAT_CYC = STEP_REPEAT_MS * CLK_FREQ_KHZ;
  localparam int COUNT_W = 16;
  localparam logic RST_LOW = 1'b0;

  function automatic logic mfi_is_nc(input mfi_code_type code);
    return code inside {FN_BLOCK_NC, FN_ESTOP_NC, FN_FSTOP_NC,
                        FN_RESET_NC, FN_SHUTOFF_NC};
  endfunction : mfi_is_nc

endpackage : mfi_pkg

// ===== hw/mfi_top.sv
`timescale 1ns/1ps
// Functional notes
// [RULE_01] block output asserted: inhibit output, coast; release: speed search
// [RULE_02] up/down inputs step frequency once, then repeatedly while held
// [RULE_03] up and down together: hold frequency, stop all stepping
// [RULE_04] counter clear held: counter stays zero, counting resumes on release
// [RULE_05] sequencer run input starts the internal step-speed program
// [RULE_06] sequencer pause input suspends a running program
// [RULE_07] codes 16 to 18 disable auxiliary motors one to three
// [RULE_08] emergency stop: stop, latch fault code until reset after cause gone
// [RULE_09] code 21 on picks current input, off voltage input, overriding setup
// [RULE_10] code 22 on picks auxiliary input, off voltage input, overriding
// [RULE_11] both analog selects on: voltage first, then current, then auxiliary
// [RULE_12] code 23 on: commands from terminals, off: from keypad, overriding
// [RULE_13] code 24 on forces linear ramps, off allows automatic ramps
// [RULE_14] forced stop acts as stop without error; fresh run needed after
// [RULE_15] parameter lock active rejects every parameter write
// [RULE_16] pid inhibit on disables pid control
// [RULE_17] code 29 selects reverse jog, only while jog terminal active
// [RULE_18] code 30 is the fault reset for a normally closed contact
// [RULE_19] codes 31 and 32 select second frequency and command sources
// [RULE_20] code 33 pulse starts sequencer; stop command cancels it
// [RULE_21] output shutoff: coast; on release restart from zero frequency
// [RULE_22] codes 07 and 08 form two-bit ramp time set selector
// [RULE_23] code 05 is external fault reset, like keypad reset key
// [RULE_24] normally closed codes act on open contact, open codes on closed
module mfi_top import mfi_pkg::*; #(
  parameter int NUM_TERM = 6,
  parameter int CNT_W = COUNT_W,
  parameter int STEP_CYC = STEP_REPEAT_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [NUM_TERM-1:0] term_level_in,
  input wire logic [NUM_TERM*CODE_W-1:0] term_code_in,
  input wire logic run_cmd_in,
  input wire logic stop_cmd_in,
  input wire logic keypad_reset_in,
  input wire logic fault_gone_in,
  input wire logic ext_jog_in,
  input wire logic count_event_in,
  input wire logic param_wr_req_in,
  output logic output_block_out,
  output logic speed_search_out,
  output logic output_shutoff_out,
  output logic restart_zero_out,
  output logic freq_up_step_out,
  output logic freq_down_step_out,
  output logic [CNT_W-1:0] count_value_out,
  output logic seq_run_out,
  output logic seq_pause_out,
  output logic [AUX_MOTORS-1:0] aux_motor_disable_out,
  output logic emerg_stop_out,
  output logic external_fault_code_out,
  output logic fault_reset_out,
  output logic freq_src_override_out,
  output mfi_asrc_type freq_src_sel_out,
  output logic freq_src_second_out,
  output logic cmd_src_override_out,
  output logic cmd_src_terminal_out,
  output logic cmd_src_second_out,
  output logic linear_ramp_out,
  output logic forced_stop_out,
  output logic run_enable_out,
  output logic param_lock_out,
  output logic param_wr_out,
  output logic param_wr_reject_out,
  output logic pid_disable_out,
  output logic jog_reverse_out,
  output logic [1:0] ramp_set_out
);

  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
    $error("mfi_top: CNT_W out of range");
  end

  // ---
  // terminal decode and input stage
  // ---
  mfi_fn_if fn_bus ();

  mfi_decode #(
    .NUM_TERM(NUM_TERM)
  ) u_decode (
    .level_in(term_level_in),
    .code_in(term_code_in),
    .fn_if(fn_bus.src)
  );

  logic [FN_COUNT-1:0] act_r, act_nxt;
  logic [FN_COUNT-1:0] cfg_r, cfg_nxt;
  logic [FN_COUNT-1:0] prev_r, prev_nxt;
  logic run_prev_r, run_prev_nxt;

  always_comb begin
    act_nxt = fn_bus.act;
    cfg_nxt = fn_bus.cfg;
    prev_nxt = act_r;
    run_prev_nxt = run_cmd_in;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      act_r <= '0;
      cfg_r <= '0;
      prev_r <= '0;
      run_prev_r <= RST_LOW;
    end else begin
      act_r <= act_nxt;
      cfg_r <= cfg_nxt;
      prev_r <= prev_nxt;
      run_prev_r <= run_prev_nxt;
    end
  end

  // ---
  // derived function levels and edges
  // ---
  logic [FN_COUNT-1:0] rise;
  logic [FN_COUNT-1:0] fall;
  logic block_on, block_was;
  logic shut_on, shut_was;
  logic estop_on, fstop_on;
  logic reset_req;
  logic run_rise;

  assign rise = act_r & ~prev_r;
  assign fall = ~act_r & prev_r;
  assign block_on = act_r[FN_BLOCK_NO] | act_r[FN_BLOCK_NC];
  assign block_was = prev_r[FN_BLOCK_NO] | prev_r[FN_BLOCK_NC];
  assign shut_on = act_r[FN_SHUTOFF_NO] | act_r[FN_SHUTOFF_NC];
  assign shut_was = prev_r[FN_SHUTOFF_NO] | prev_r[FN_SHUTOFF_NC];
  assign estop_on = act_r[FN_ESTOP_NO] | act_r[FN_ESTOP_NC];
  assign fstop_on = act_r[FN_FSTOP_NO] | act_r[FN_FSTOP_NC];
  assign run_rise = run_cmd_in & ~run_prev_r;
  assign reset_req = rise[FN_RESET_NO] // see [RULE_23]
                     | rise[FN_RESET_NC] // see [RULE_18]
                     | keypad_reset_in;

  // ---
  // frequency up and down stepping
  // ---
  mfi_updown #(
    .REPEAT_CYC(STEP_CYC)
  ) u_updown (
    .clk_in(clk_sys_in),
    .rstn_in(rstn_in),
    .up_in(act_r[FN_FREQ_UP]),
    .down_in(act_r[FN_FREQ_DOWN]),
    .step_up_out(freq_up_step_out),
    .step_down_out(freq_down_step_out)
  );

  // ---
  // control state
  // ---
  logic block_r, block_nxt;
  logic search_r, search_nxt;
  logic shut_r, shut_nxt;
  logic zero_r, zero_nxt;
  logic [CNT_W-1:0] count_r, count_nxt;
  logic shot_r, shot_nxt;
  logic seq_run_r, seq_run_nxt;
  logic seq_pause_r, seq_pause_nxt;
  logic [AUX_MOTORS-1:0] aux_r, aux_nxt;
  logic fault_r, fault_nxt;
  logic reset_r, reset_nxt;
  logic fsrc_ovr_r, fsrc_ovr_nxt;
  mfi_asrc_type fsrc_r, fsrc_nxt;
  logic fsrc2_r, fsrc2_nxt;
  logic csrc_ovr_r, csrc_ovr_nxt;
  logic csrc_term_r, csrc_term_nxt;
  logic csrc2_r, csrc2_nxt;
  logic linear_r, linear_nxt;
  logic fstop_r, fstop_nxt;
  logic run_en_r, run_en_nxt;
  logic lock_r, lock_nxt;
  logic wr_r, wr_nxt;
  logic wr_rej_r, wr_rej_nxt;
  logic pid_off_r, pid_off_nxt;
  logic jog_rev_r, jog_rev_nxt;
  logic [1:0] ramp_r, ramp_nxt;

  always_comb begin
    // output blocking and shutoff
    block_nxt = block_on; // see [RULE_01]
    search_nxt = block_was & ~block_on; // see [RULE_01]
    shut_nxt = shut_on; // see [RULE_21]
    zero_nxt = shut_was & ~shut_on; // see [RULE_21]

    // event counter
    if (act_r[FN_CNT_CLEAR]) begin
      count_nxt = '0; // see [RULE_04]
    end else if (count_event_in) begin
      count_nxt = count_r + CNT_W'(1);
    end else begin
      count_nxt = count_r;
    end

    // sequencer
    if (rise[FN_SEQ_SHOT]) begin
      shot_nxt = 1'b1; // see [RULE_20]
    end else if (stop_cmd_in || fstop_on || estop_on) begin
      shot_nxt = 1'b0; // see [RULE_20]
    end else begin
      shot_nxt = shot_r;
    end
    seq_run_nxt = act_r[FN_SEQ_RUN] | shot_nxt; // see [RULE_05]
    seq_pause_nxt = act_r[FN_SEQ_PAUSE] & seq_run_nxt; // see [RULE_06]

    // auxiliary motors
    for (int m = 0; m < AUX_MOTORS; m++) begin
      aux_nxt[m] = act_r[int'(FN_AUX_MOTOR1) + m]; // see [RULE_07]
    end

    // emergency stop latch, the set wins over a reset
    reset_nxt = reset_req; // see [RULE_23]
    if (estop_on) begin
      fault_nxt = 1'b1; // see [RULE_08]
    end else if (reset_req && fault_gone_in) begin
      fault_nxt = 1'b0; // see [RULE_08]
    end else begin
      fault_nxt = fault_r;
    end

    // analog frequency source
    fsrc_ovr_nxt = cfg_r[FN_SEL_CURRENT] | cfg_r[FN_SEL_AUX]; // see [RULE_09]
    if (act_r[FN_SEL_CURRENT] && act_r[FN_SEL_AUX]) begin
      fsrc_nxt = SRC_VOLTAGE; // see [RULE_11]
    end else if (act_r[FN_SEL_CURRENT]) begin
      fsrc_nxt = SRC_CURRENT; // see [RULE_09]
    end else if (act_r[FN_SEL_AUX]) begin
      fsrc_nxt = SRC_AUXILIARY; // see [RULE_10]
    end else begin
      fsrc_nxt = SRC_VOLTAGE;
    end
    fsrc2_nxt = act_r[FN_SECOND_FREQ]; // see [RULE_19]

    // operation command source
    csrc_ovr_nxt = cfg_r[FN_CMD_TERMINAL]; // see [RULE_12]
    csrc_term_nxt = act_r[FN_CMD_TERMINAL]; // see [RULE_12]
    csrc2_nxt = act_r[FN_SECOND_CMD]; // see [RULE_19]

    // ramp control
    linear_nxt = act_r[FN_LINEAR_RAMP]; // see [RULE_13]
    ramp_nxt = {act_r[FN_RAMP_SEL2], act_r[FN_RAMP_SEL1]}; // see [RULE_22]

    // forced stop and run permission
    fstop_nxt = fstop_on; // see [RULE_14]
    if (fstop_on || stop_cmd_in || estop_on || fault_r) begin
      run_en_nxt = 1'b0; // see [RULE_14]
    end else if (run_rise) begin
      run_en_nxt = 1'b1; // see [RULE_14]
    end else begin
      run_en_nxt = run_en_r;
    end

    // parameter lock
    lock_nxt = act_r[FN_PARAM_LOCK]; // see [RULE_15]
    wr_nxt = param_wr_req_in & ~act_r[FN_PARAM_LOCK]; // see [RULE_15]
    wr_rej_nxt = param_wr_req_in & act_r[FN_PARAM_LOCK]; // see [RULE_15]

    // pid and jog
    pid_off_nxt = act_r[FN_PID_OFF]; // see [RULE_16]
    jog_rev_nxt = act_r[FN_JOG_REVERSE] & ext_jog_in; // see [RULE_17]
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      block_r <= 1'b0;
      search_r <= 1'b0;
      shut_r <= 1'b0;
      zero_r <= 1'b0;
      count_r <= '0;
      shot_r <= 1'b0;
      seq_run_r <= 1'b0;
      seq_pause_r <= 1'b0;
      aux_r <= '0;
      fault_r <= 1'b0;
      reset_r <= 1'b0;
      fsrc_ovr_r <= 1'b0;
      fsrc_r <= SRC_VOLTAGE;
      fsrc2_r <= 1'b0;
      csrc_ovr_r <= 1'b0;
      csrc_term_r <= 1'b0;
      csrc2_r <= 1'b0;
      linear_r <= 1'b0;
      fstop_r <= 1'b0;
      run_en_r <= 1'b0;
      lock_r <= 1'b0;
      wr_r <= 1'b0;
      wr_rej_r <= 1'b0;
      pid_off_r <= 1'b0;
      jog_rev_r <= 1'b0;
      ramp_r <= 2'h0;
    end else begin
      block_r <= block_nxt;
      search_r <= search_nxt;
      shut_r <= shut_nxt;
      zero_r <= zero_nxt;
      count_r <= count_nxt;
      shot_r <= shot_nxt;
      seq_run_r <= seq_run_nxt;
      seq_pause_r <= seq_pause_nxt;
      aux_r <= aux_nxt;
      fault_r <= fault_nxt;
      reset_r <= reset_nxt;
      fsrc_ovr_r <= fsrc_ovr_nxt;
      fsrc_r <= fsrc_nxt;
      fsrc2_r <= fsrc2_nxt;
      csrc_ovr_r <= csrc_ovr_nxt;
      csrc_term_r <= csrc_term_nxt;
      csrc2_r <= csrc2_nxt;
      linear_r <= linear_nxt;
      fstop_r <= fstop_nxt;
      run_en_r <= run_en_nxt;
      lock_r <= lock_nxt;
      wr_r <= wr_nxt;
      wr_rej_r <= wr_rej_nxt;
      pid_off_r <= pid_off_nxt;
      jog_rev_r <= jog_rev_nxt;
      ramp_r <= ramp_nxt;
    end
  end

  // ---
  // outputs
  // ---
  assign output_block_out = block_r;
  assign speed_search_out = search_r;
  assign output_shutoff_out = shut_r;
  assign restart_zero_out = zero_r;
  assign count_value_out = count_r;
  assign seq_run_out = seq_run_r;
  assign seq_pause_out = seq_pause_r;
  assign aux_motor_disable_out = aux_r;
  assign emerg_stop_out = fault_r;
  assign external_fault_code_out = fault_r;
  assign fault_reset_out = reset_r;
  assign freq_src_override_out = fsrc_ovr_r;
  assign freq_src_sel_out = fsrc_r;
  assign freq_src_second_out = fsrc2_r;
  assign cmd_src_override_out = csrc_ovr_r;
  assign cmd_src_terminal_out = csrc_term_r;
  assign cmd_src_second_out = csrc2_r;
  assign linear_ramp_out = linear_r;
  assign forced_stop_out = fstop_r;
  assign run_enable_out = run_en_r;
  assign param_lock_out = lock_r;
  assign param_wr_out = wr_r;
  assign param_wr_reject_out = wr_rej_r;
  assign pid_disable_out = pid_off_r;
  assign jog_reverse_out = jog_rev_r;
  assign ramp_set_out = ramp_r;

endmodule : mfi_top

// ===== hw/mfi_updown.sv
`timescale 1ns/1ps
module mfi_updown import mfi_pkg::*; #(
  parameter int REPEAT_CYC = STEP_REPEAT_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic up_in,
  input wire logic down_in,
  output logic step_up_out,
  output logic step_down_out
);

  localparam int CW = $clog2(REPEAT_CYC + 1);

  if (REPEAT_CYC < 2) begin : g_bad
    $error("mfi_updown: REPEAT_CYC below 2");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_UP = 3'b010,
    ST_DOWN = 3'b100
  } mfi_step_type;

  mfi_step_type state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic up_nxt, down_nxt;

  // ---
  // stepping control
  // ---
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    up_nxt = 1'b0;
    down_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        cnt_nxt = '0;
        if (up_in && !down_in) begin
          up_nxt = 1'b1; // see [RULE_02]
          state_nxt = ST_UP;
        end else if (down_in && !up_in) begin
          down_nxt = 1'b1; // see [RULE_02]
          state_nxt = ST_DOWN;
        end
      end
      ST_UP, ST_DOWN: begin
        if ((state_r == ST_UP) ? (!up_in || down_in)
                               : (!down_in || up_in)) begin
          state_nxt = ST_IDLE; // see [RULE_03]
          cnt_nxt = '0;
        end else if (cnt_r == CW'(REPEAT_CYC - 1)) begin
          cnt_nxt = '0;
          up_nxt = (state_r == ST_UP); // see [RULE_02]
          down_nxt = (state_r == ST_DOWN);
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      step_up_out <= 1'b0;
      step_down_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      step_up_out <= up_nxt;
      step_down_out <= down_nxt;
    end
  end

endmodule : mfi_updown

// ===== test/mfi_contacts.sv
`timescale 1ns/1ps
module mfi_contacts #(
  parameter int NUM_TERM = 6
) (
  input wire logic [NUM_TERM-1:0] closed_in,
  output logic [NUM_TERM-1:0] level_out
);
  // ---
  // contact levels
  // ---
  // closed contact reads 1, open reads 0, whatever the code
  assign level_out = closed_in;
endmodule : mfi_contacts

// ===== test/mfi_top_assertions.sv
`timescale 1ns/1ps
module mfi_top_assertions import mfi_pkg::*; #(
  parameter int CNT_W = COUNT_W
) (
  input logic clk_sys_in,
  input logic rstn_in,
  input logic run_cmd_in,
  input logic count_event_in,
  input logic param_wr_req_in,
  input logic speed_search_out,
  input logic freq_up_step_out,
  input logic freq_down_step_out,
  input logic [CNT_W-1:0] count_value_out,
  input logic seq_run_out,
  input logic seq_pause_out,
  input logic emerg_stop_out,
  input logic external_fault_code_out,
  input logic freq_src_override_out,
  input mfi_asrc_type freq_src_sel_out,
  input logic forced_stop_out,
  input logic run_enable_out,
  input logic param_lock_out,
  input logic param_wr_out,
  input logic param_wr_reject_out
);
  // ---
  // properties
  // ---
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence s_lone(x);
    x ##1 !x;
  endsequence
  sequence s_run_rise;
    $past(run_cmd_in) && !$past(run_cmd_in, 2);
  endsequence
  property p_step_excl;
    !(freq_up_step_out && freq_down_step_out);
  endproperty
  a_step_excl: assert property (p_step_excl)
    else $error("up and down steps together");
  property p_up_lone;
    freq_up_step_out |-> s_lone(freq_up_step_out);
  endproperty
  a_up_lone: assert property (p_up_lone)
    else $error("up step longer than one cycle");
  property p_search;
    speed_search_out |-> s_lone(speed_search_out);
  endproperty
  a_search: assert property (p_search)
    else $error("speed search longer than one cycle");
  property p_fault_disp;
    emerg_stop_out == external_fault_code_out;
  endproperty
  a_fault_disp: assert property (p_fault_disp)
    else $error("fault code differs from stop");
  property p_run_clear;
    emerg_stop_out || forced_stop_out |-> !run_enable_out;
  endproperty
  a_run_clear: assert property (p_run_clear)
    else $error("run enabled during stop");
  property p_run_rise;
    $rose(run_enable_out) |-> s_run_rise;
  endproperty
  a_run_rise: assert property (p_run_rise)
    else $error("run enabled without run edge");
  property p_count_inc;
    count_value_out > $past(count_value_out) |-> $past(count_event_in)
      && count_value_out == CNT_W'($past(count_value_out) + 1);
  endproperty
  a_count_inc: assert property (p_count_inc)
    else $error("counter step wrong");
  property p_wr;
    $past(param_wr_req_in) |-> param_wr_reject_out == param_lock_out
      && param_wr_out == !param_lock_out;
  endproperty
  a_wr: assert property (p_wr)
    else $error("parameter write outcome wrong");
  property p_pause;
    seq_pause_out |-> seq_run_out;
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause without run");
  property p_src;
    !freq_src_override_out |-> freq_src_sel_out == SRC_VOLTAGE;
  endproperty
  a_src: assert property (p_src)
    else $error("source moved without override");
endmodule : mfi_top_assertions

bind mfi_top mfi_top_assertions #(.CNT_W(CNT_W)) mfi_top_assertions_inst (.*);

// ===== test/mfi_top_test.sv
`timescale 1ns/1ps
module mfi_top_test import mfi_pkg::*;;
  // ---
  // bench
  // ---
  localparam int NT = 6;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [NT-1:0] cl = '0;
  logic [NT-1:0] term_level_in;
  logic [NT*CODE_W-1:0] term_code_in = '0;
  logic run_cmd_in = 1'b0, stop_cmd_in = 1'b0, keypad_reset_in = 1'b0;
  logic fault_gone_in = 1'b0, ext_jog_in = 1'b0, count_event_in = 1'b0;
  logic param_wr_req_in = 1'b0;
  logic output_block_out, speed_search_out, output_shutoff_out;
  logic restart_zero_out, freq_up_step_out, freq_down_step_out;
  logic seq_run_out, seq_pause_out, emerg_stop_out, external_fault_code_out;
  logic fault_reset_out, freq_src_override_out, freq_src_second_out;
  logic cmd_src_override_out, cmd_src_terminal_out, cmd_src_second_out;
  logic linear_ramp_out, forced_stop_out, run_enable_out, param_lock_out;
  logic param_wr_out, param_wr_reject_out, pid_disable_out, jog_reverse_out;
  logic [COUNT_W-1:0] count_value_out;
  logic [AUX_MOTORS-1:0] aux_motor_disable_out;
  logic [1:0] ramp_set_out;
  mfi_asrc_type freq_src_sel_out;
  int fails = 0;
  int samples_checked = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  mfi_contacts #(.NUM_TERM(NT)) mfi_contacts_inst (
    .closed_in(cl),
    .level_out(term_level_in)
  );
  mfi_top #(.NUM_TERM(NT), .STEP_CYC(8)) mfi_top_inst (.*);
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : tick
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic cfg(input mfi_code_type c0, c1, c2, c3, c4, c5,
                     input logic [NT-1:0] idle);
    term_code_in = {c5, c4, c3, c2, c1, c0};
    cl = idle;
    tick(4);
  endtask : cfg
  task automatic steps(input int n, output int nu, output int nd);
    nu = 0;
    nd = 0;
    repeat (n) begin
      tick(1);
      nu += int'(freq_up_step_out === 1'b1);
      nd += int'(freq_down_step_out === 1'b1);
    end
  endtask : steps
  task automatic t_block;
    cfg(FN_BLOCK_NO, FN_BLOCK_NC, FN_SHUTOFF_NO, FN_SHUTOFF_NC, 6'h00,
        6'h00, 6'h0a);
    cl[0] = 1'b1;
    tick(2);
    chk(output_block_out && !speed_search_out, "block");
    cl[0] = 1'b0;
    tick(2);
    chk(!output_block_out && speed_search_out, "search");
    cl[1] = 1'b0;
    tick(2);
    chk(output_block_out, "nc block");
    cl[1] = 1'b1;
    cl[2] = 1'b1;
    tick(2);
    chk(output_shutoff_out && !restart_zero_out, "shutoff");
    cl[2] = 1'b0;
    tick(2);
    chk(!output_shutoff_out && restart_zero_out, "zero");
    cl[3] = 1'b0;
    tick(2);
    chk(output_shutoff_out, "nc shutoff");
  endtask : t_block
  task automatic t_updown;
    int nu, nd;
    cfg(FN_FREQ_UP, FN_FREQ_DOWN, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00);
    cl[0] = 1'b1;
    steps(20, nu, nd);
    chk(nu == 3 && nd == 0, "held up");
    cl[1] = 1'b1;
    steps(20, nu, nd);
    chk(nu == 0 && nd == 0, "both held");
    cl[1] = 1'b0;
    steps(5, nu, nd);
    chk(nu == 1 && nd == 0, "fresh step");
    cl = '0;
    tick(4);
    cl[1] = 1'b1;
    steps(3, nu, nd);
    chk(nu == 0 && nd == 1, "down step");
  endtask : t_updown
  task automatic t_count;
    cfg(FN_CNT_CLEAR, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00);
    count_event_in = 1'b1;
    tick(3);
    count_event_in = 1'b0;
    cl[0] = 1'b1;
    tick(3);
    count_event_in = 1'b1;
    tick(4);
    chk(count_value_out === '0, "clear held");
    count_event_in = 1'b0;
    cl[0] = 1'b0;
    tick(3);
    count_event_in = 1'b1;
    tick(5);
    count_event_in = 1'b0;
    tick(1);
    chk(count_value_out === 16'h0005, "count");
  endtask : t_count
  task automatic t_estop;
    cfg(FN_ESTOP_NO, FN_RESET_NO, FN_FSTOP_NC, FN_FSTOP_NO, 6'h00,
        6'h00, 6'h04);
    run_cmd_in = 1'b1;
    tick(2);
    cl[0] = 1'b1;
    tick(2);
    chk(emerg_stop_out && external_fault_code_out, "estop");
    cl[0] = 1'b0;
    cl[1] = 1'b1;
    tick(3);
    chk(emerg_stop_out, "fault kept");
    cl[1] = 1'b0;
    fault_gone_in = 1'b1;
    tick(2);
    cl[1] = 1'b1;
    tick(2);
    chk(fault_reset_out && !emerg_stop_out, "reset");
    cl[1] = 1'b0;
    run_cmd_in = 1'b0;
    tick(1);
    run_cmd_in = 1'b1;
    tick(2);
    chk(run_enable_out, "rearm");
    cl[3] = 1'b1;
    tick(2);
    chk(forced_stop_out && !emerg_stop_out, "fstop");
    cl[3] = 1'b0;
    cl[2] = 1'b0;
    tick(2);
    chk(forced_stop_out, "nc fstop");
    cl[2] = 1'b1;
    tick(3);
    chk(!run_enable_out, "no restart");
    cl[0] = 1'b1;
    tick(2);
    cl[0] = 1'b0;
    tick(2);
    keypad_reset_in = 1'b1;
    tick(1);
    keypad_reset_in = 1'b0;
    tick(1);
    chk(!emerg_stop_out, "keypad reset");
    run_cmd_in = 1'b0;
  endtask : t_estop
  task automatic t_decode;
    mfi_asrc_type want;
    logic [NT-1:0] v;
    cfg(FN_SEL_CURRENT, FN_SEL_AUX, FN_CMD_TERMINAL, FN_LINEAR_RAMP,
        FN_RAMP_SEL1, FN_RAMP_SEL2, 6'h00);
    for (int i = 0; i < 64; i++) begin
      v = NT'(i);
      cl = v;
      tick(3);
      want = v[0] == v[1] ? SRC_VOLTAGE : v[0] ? SRC_CURRENT : SRC_AUXILIARY;
      chk(freq_src_override_out === 1'b1, "ovr");
      chk(freq_src_sel_out === want, "src");
      chk(cmd_src_override_out === 1'b1, "cmd ovr");
      chk(cmd_src_terminal_out === v[2], "cmd");
      chk(linear_ramp_out === v[3], "ramp");
      chk(ramp_set_out === v[5:4], "ramp set");
    end
  endtask : t_decode
  task automatic t_misc;
    logic [6:0] v;
    cfg(FN_AUX_MOTOR1, 6'h11, 6'h12, FN_PARAM_LOCK, FN_PID_OFF,
        FN_JOG_REVERSE, 6'h00);
    for (int i = 0; i < 128; i++) begin
      v = 7'(i);
      cl = v[5:0];
      ext_jog_in = v[6];
      tick(3);
      chk(aux_motor_disable_out === v[2:0], "aux");
      chk(param_lock_out === v[3], "lock");
      chk(pid_disable_out === v[4], "pid");
      chk(jog_reverse_out === (v[5] & v[6]), "jog");
    end
    cl = 6'h08;
    tick(3);
    param_wr_req_in = 1'b1;
    tick(1);
    chk(param_wr_reject_out && !param_wr_out, "locked");
    cl = '0;
    tick(3);
    chk(param_wr_out && !param_wr_reject_out, "open");
    param_wr_req_in = 1'b0;
    ext_jog_in = 1'b0;
  endtask : t_misc
  task automatic t_seq;
    cfg(FN_SEQ_RUN, FN_SEQ_PAUSE, FN_SEQ_SHOT, FN_SECOND_FREQ,
        FN_SECOND_CMD, FN_RESET_NC, 6'h20);
    cl[0] = 1'b1;
    tick(2);
    chk(seq_run_out && !seq_pause_out, "run");
    cl[1] = 1'b1;
    tick(2);
    chk(seq_pause_out, "pause");
    cl[1:0] = 2'h0;
    tick(3);
    cl[2] = 1'b1;
    tick(1);
    cl[2] = 1'b0;
    tick(4);
    chk(seq_run_out, "one shot");
    stop_cmd_in = 1'b1;
    tick(3);
    chk(!seq_run_out, "cancel");
    stop_cmd_in = 1'b0;
    cl[4:3] = 2'h3;
    tick(2);
    chk(freq_src_second_out && cmd_src_second_out, "second");
    cl[3] = 1'b0;
    cl[5] = 1'b0;
    tick(2);
    chk(!freq_src_second_out && fault_reset_out, "ncr");
    tick(1);
    chk(!fault_reset_out, "reset pulse");
  endtask : t_seq
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (10) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rstn_in = 1'b1;
    tick(2);
    t_block();
    t_updown();
    t_count();
    t_estop();
    t_decode();
    t_misc();
    t_seq();
    print_verdict();
  end
  initial begin
    #100000;
    fails++;
    $display("BAD %0t watchdog", $time);
    print_verdict();
  end
endmodule : mfi_top_test
